//--- pkg/ccd_cfg.svh
`ifndef CCD_CFG_SVH
`define CCD_CFG_SVH

// ********************************
// Register map (byte addresses)
// ********************************
`define CCD_AW 12
`define CCD_OFS_ENA 12'h000
`define CCD_OFS_SEL 12'h004
`define CCD_OFS_DBC 12'h008
`define CCD_OFS_SRC 12'h00c
`define CCD_OFS_STS 12'h010
`define CCD_OFS_MSK 12'h014

// ********************************
// Reset values and writable masks
// ********************************
`define CCD_ENA_RST 8'h00
`define CCD_ENA_WMASK 8'hdf
`define CCD_SEL_RST 8'h00
`define CCD_SEL_WMASK 8'h71
`define CCD_DBC_RST 6'h00
`define CCD_DBC_W 6
`define CCD_REG_W 8

// ********************************
// Field positions
// ********************************
`define CCD_B_C3INV 7
`define CCD_B_C2INV 6
`define CCD_B_IRQINV 4
`define CCD_B_C0RES 7
`define CCD_B_C3SEL_LO 6
`define CCD_B_C3SEL_HI 0
`define CCD_B_C2SEL_HI 5
`define CCD_B_C2SEL_LO 4
`define CCD_B_C1SEL 2

// ********************************
// Debounce timing
// ********************************
`define CCD_SYS_HZ 125000000
`define CCD_DBC_HZ 8000000
`define CCD_DBC_DIV ((`CCD_SYS_HZ + `CCD_DBC_HZ - 1) / `CCD_DBC_HZ)
`define CCD_DIV_W 5
`define CCD_DBC_SAT 6'd48

// ********************************
// Interrupt events
// ********************************
`define CCD_EVT_N 2
`define CCD_EVT_IRQ 0
`define CCD_EVT_C0 1

`endif

//--- pkg/ccd_pkg.sv
package ccd_pkg;
	typedef logic [5:0] ccd_dbc_time_t;
	typedef enum logic {CCD_SRC_PIN, CCD_SRC_COMPARATOR_ZERO} ccd_irq_src_t;
endpackage

//--- pkg/ccd_link_if.sv
`include "ccd_cfg.svh"
interface ccd_link_if;
	logic src;
	logic [`CCD_DBC_W-1:0] dbc_time;
	logic reload;
	logic tick;
	logic filt;
	logic [`CCD_EVT_N-1:0] evt;
	logic wr_status;
	logic wr_mask;
	logic [`CCD_EVT_N-1:0] wdata;
	logic [`CCD_EVT_N-1:0] status;
	logic [`CCD_EVT_N-1:0] mask;
	logic irq;
	modport ctl(output src, dbc_time, reload, tick, evt, wr_status, wr_mask, wdata,
		input filt, status, mask, irq);
	modport flt(input src, dbc_time, reload, tick, output filt);
	modport irqc(input evt, wr_status, wr_mask, wdata, output status, mask, irq);
endinterface

//--- rtl/ccd_debounce.sv
`include "ccd_cfg.svh"
module ccd_debounce
	import ccd_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic nrst,
	// Filter link
	ccd_link_if.flt lk
);
	logic filt_r;
	logic [`CCD_DBC_W-1:0] cnt_r;
	wire [`CCD_DBC_W-1:0] limit = (lk.dbc_time > `CCD_DBC_SAT) ? `CCD_DBC_SAT : lk.dbc_time;
	wire [`CCD_DBC_W-1:0] cnt_inc = cnt_r + 6'h01;
	wire bypass = (lk.dbc_time == 6'h00);
	wire settle = lk.tick && (cnt_inc >= limit);

	assign lk.filt = filt_r;

	// Write of a new time drops the output; a source still high rises again and raises a request
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			filt_r <= 1'b0;
			cnt_r <= 6'h00;
		end else if (lk.reload) begin
			filt_r <= 1'b0;
			cnt_r <= 6'h00;
		end else if (bypass || lk.src == filt_r) begin
			filt_r <= lk.src;
			cnt_r <= 6'h00;
		end else if (settle) begin
			filt_r <= lk.src;
			cnt_r <= 6'h00;
		end else if (lk.tick) begin
			cnt_r <= cnt_inc;
		end
	end

	dbc_bypass_a: assert property (@(posedge clk) disable iff (!nrst)
		bypass && !lk.reload |=> filt_r == $past(lk.src))
		else $error("zero debounce time does not pass the source");
	dbc_sat_a: assert property (@(posedge clk) disable iff (!nrst)
		cnt_r < `CCD_DBC_SAT)
		else $error("debounce count passed saturation");
	dbc_reload_a: assert property (@(posedge clk) disable iff (!nrst)
		lk.reload |=> !filt_r)
		else $error("debounce output not dropped on time write");
	dbc_sat_c: cover property (@(posedge clk) disable iff (!nrst)
		lk.dbc_time == 6'h3f && settle);
endmodule

//--- rtl/ccd_irq_ctrl.sv
`include "ccd_cfg.svh"
module ccd_irq_ctrl
	import ccd_pkg::*;
(
	// System
	input wire logic clk,
	input wire logic nrst,
	// Status link
	ccd_link_if.irqc lk
);
	logic [`CCD_EVT_N-1:0] status_r;
	logic [`CCD_EVT_N-1:0] mask_r;
	// A new event wins over a one written in the same cycle
	wire [`CCD_EVT_N-1:0] clr = lk.wr_status ? lk.wdata : '0;
	wire [`CCD_EVT_N-1:0] status_nxt = (status_r & ~clr) | lk.evt;

	assign lk.status = status_r;
	assign lk.mask = mask_r;
	assign lk.irq = |(status_r & mask_r);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			status_r <= '0;
			mask_r <= '0;
		end else begin
			status_r <= status_nxt;
			if (lk.wr_mask) begin
				mask_r <= lk.wdata;
			end
		end
	end

	irq_raise_a: assert property (@(posedge clk) disable iff (!nrst)
		|(lk.evt & mask_r) && !lk.wr_mask |=> lk.irq)
		else $error("unmasked event did not raise the interrupt");
	evt_sticky_a: assert property (@(posedge clk) disable iff (!nrst)
		|lk.evt |=> (status_r & $past(lk.evt)) == $past(lk.evt))
		else $error("event lost against a clear");
endmodule

//--- rtl/ccd_top.sv
// How it works
// - The comparator 0 result bit reads one when comparator 0 is on and plus exceeds minus, else zero.
// - The comparator 3 minus select routes the comparator 0 plus pin at 00, the amp at 01.
// - The comparator 1 minus select routes the comparator 0 plus pin; one is reserved.
// - The debounce time passes the source at zero and waits N-1 to N ticks, capped at 48.
// - A source that is high while the debounce time is rewritten raises a request.
// - The comparator 0 output is low when it is off or its plus is below its minus.
// - Unimplemented bits ignore writes and read as zero.
`include "ccd_cfg.svh"
module ccd_top
	import ccd_pkg::*;
#(
	parameter int DBC_DIV = `CCD_DBC_DIV
)(
	// System
	input wire logic clk,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`CCD_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Analog comparators
	input wire logic [3:0] cmp_raw,
	output logic [3:0] cmp_power_on,
	output logic [1:0] comparator_three_neg_input_sel,
	output logic comparator_one_neg_input_sel,
	output logic comparator_two_input_sel_hi,
	output logic comparator_two_input_sel_lo,
	output logic comparator_three_out,
	output logic comparator_two_out,
	// External interrupt
	input wire logic irq_input_pin,
	output logic external_irq_request,
	output logic irq
);
	// ********************************
	// Bus decode
	// ********************************
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_ena = (paddr == `CCD_OFS_ENA);
	wire hit_sel = (paddr == `CCD_OFS_SEL);
	wire hit_dbc = (paddr == `CCD_OFS_DBC);
	wire hit_src = (paddr == `CCD_OFS_SRC);
	wire hit_sts = (paddr == `CCD_OFS_STS);
	wire hit_msk = (paddr == `CCD_OFS_MSK);
	wire hit_any = hit_ena || hit_sel || hit_dbc || hit_src || hit_sts || hit_msk;
	wire wr = access && pwrite;
	wire wr_ena = wr && hit_ena;
	wire wr_sel = wr && hit_sel;
	wire wr_dbc = wr && hit_dbc;
	wire wr_src = wr && hit_src;
	wire [`CCD_REG_W-1:0] wbyte = pwdata[`CCD_REG_W-1:0];

	// Zero wait states: read data is captured in the setup cycle
	assign pready = access;
	assign pslverr = access && !hit_any;

	// ********************************
	// Control registers
	// ********************************
	logic [`CCD_REG_W-1:0] ena_r;
	logic [`CCD_REG_W-1:0] sel_r;
	logic [`CCD_DBC_W-1:0] dbc_r;
	ccd_irq_src_t src_r;
	logic [31:0] prdata_r;
	logic [`CCD_DIV_W-1:0] div_r;
	logic irq_lvl_r;
	logic c0_out_r;

	// Only writable positions are stored, so unimplemented bits stay zero
	wire [`CCD_REG_W-1:0] ena_nxt = wbyte & `CCD_ENA_WMASK;
	wire [1:0] c3_code_new = {wbyte[`CCD_B_C3SEL_HI], wbyte[`CCD_B_C3SEL_LO]};
	// A reserved comparator 3 code keeps the old routing rather than float the input
	wire c3_keep = c3_code_new[1];
	wire [`CCD_REG_W-1:0] sel_wr = wbyte & `CCD_SEL_WMASK;
	wire [`CCD_REG_W-1:0] sel_nxt = c3_keep ?
		{sel_r[7], sel_r[`CCD_B_C3SEL_LO], sel_wr[5:1], sel_r[`CCD_B_C3SEL_HI]} : sel_wr;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ena_r <= `CCD_ENA_RST;
			sel_r <= `CCD_SEL_RST;
			dbc_r <= `CCD_DBC_RST;
			src_r <= CCD_SRC_PIN;
		end else begin
			if (wr_ena) begin
				ena_r <= ena_nxt;
			end
			if (wr_sel) begin
				sel_r <= sel_nxt;
			end
			if (wr_dbc) begin
				dbc_r <= wbyte[`CCD_DBC_W-1:0];
			end
			if (wr_src) begin
				src_r <= ccd_irq_src_t'(wbyte[0]);
			end
		end
	end

	// ********************************
	// Comparator outputs
	// ********************************
	wire [3:0] cmp_live = cmp_raw & ena_r[3:0];
	wire c0_out = cmp_live[0];
	assign cmp_power_on = ena_r[3:0];
	assign comparator_three_neg_input_sel = {sel_r[`CCD_B_C3SEL_HI], sel_r[`CCD_B_C3SEL_LO]};
	// The reserved one is never stored, so comparator 1 always sees the comparator 0 plus pin
	assign comparator_one_neg_input_sel = sel_r[`CCD_B_C1SEL];
	assign comparator_two_input_sel_hi = sel_r[`CCD_B_C2SEL_HI];
	assign comparator_two_input_sel_lo = sel_r[`CCD_B_C2SEL_LO];
	assign comparator_three_out = cmp_live[3] ^ ena_r[`CCD_B_C3INV];
	assign comparator_two_out = cmp_live[2] ^ ena_r[`CCD_B_C2INV];

	// ********************************
	// Debounce clock divider
	// ********************************
	wire div_end = (div_r == `CCD_DIV_W'(DBC_DIV - 1));
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			div_r <= '0;
		end else begin
			div_r <= div_end ? '0 : div_r + `CCD_DIV_W'(1);
		end
	end

	// ********************************
	// Interrupt path
	// ********************************
	ccd_link_if lk();

	// Software is expected to hold the source low while rewriting; if not, a request follows
	assign lk.src = (src_r == CCD_SRC_COMPARATOR_ZERO) ? c0_out : irq_input_pin;
	assign lk.dbc_time = dbc_r;
	assign lk.reload = wr_dbc;
	assign lk.tick = div_end;
	wire irq_lvl = lk.filt ^ ena_r[`CCD_B_IRQINV];
	wire irq_rise = irq_lvl && !irq_lvl_r;
	wire c0_rise = c0_out && !c0_out_r;
	assign lk.evt = {c0_rise, irq_rise};
	assign lk.wr_status = wr && hit_sts;
	assign lk.wr_mask = wr && hit_msk;
	assign lk.wdata = wbyte[`CCD_EVT_N-1:0];

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_lvl_r <= 1'b0;
			c0_out_r <= 1'b0;
			external_irq_request <= 1'b0;
		end else begin
			irq_lvl_r <= irq_lvl;
			c0_out_r <= c0_out;
			external_irq_request <= irq_rise;
		end
	end

	ccd_debounce u_dbc (
		.clk(clk),
		.nrst(nrst),
		.lk(lk.flt)
	);

	ccd_irq_ctrl u_irq (
		.clk(clk),
		.nrst(nrst),
		.lk(lk.irqc)
	);

	assign irq = lk.irq;

	// ********************************
	// Read path
	// ********************************
	wire [`CCD_REG_W-1:0] rd_sel = {c0_out, sel_r[6:0]};
	wire [`CCD_REG_W-1:0] rd_byte =
		hit_ena ? ena_r :
		hit_sel ? rd_sel :
		hit_dbc ? {2'h0, dbc_r} :
		hit_src ? {7'h00, src_r} :
		hit_sts ? {6'h00, lk.status} :
		hit_msk ? {6'h00, lk.mask} : 8'h00;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_r <= 32'h0;
		end else if (setup && !pwrite) begin
			prdata_r <= {24'h0, rd_byte};
		end
	end
	assign prdata = prdata_r;

	// ********************************
	// Checks
	// ********************************
	pwr_write_a: assert property (@(posedge clk) disable iff (!nrst)
		wr_ena |=> cmp_power_on == $past(pwdata[3:0]))
		else $error("power bits do not follow the written value");
	c0_off_low_a: assert property (@(posedge clk) disable iff (!nrst)
		!cmp_power_on[0] |-> !lk.src || src_r == CCD_SRC_PIN)
		else $error("comparator 0 output high while off");
	result_read_a: assert property (@(posedge clk) disable iff (!nrst)
		setup && !pwrite && hit_sel ##1 access |-> prdata[7] == $past(cmp_raw[0] & ena_r[0]))
		else $error("result bit does not show comparator 0");
	c3_rsv_a: assert property (@(posedge clk) disable iff (!nrst)
		!comparator_three_neg_input_sel[1])
		else $error("reserved comparator 3 select applied");
	c3_keep_a: assert property (@(posedge clk) disable iff (!nrst)
		wr_sel && c3_keep |=> $stable(comparator_three_neg_input_sel))
		else $error("reserved code changed comparator 3 routing");
	c1_rsv_a: assert property (@(posedge clk) disable iff (!nrst)
		!comparator_one_neg_input_sel)
		else $error("reserved comparator 1 select applied");
	unimpl_zero_a: assert property (@(posedge clk) disable iff (!nrst)
		access && !pwrite && hit_dbc |-> prdata[31:6] == 26'h0)
		else $error("unimplemented debounce bits read nonzero");
	c2_inv_a: assert property (@(posedge clk) disable iff (!nrst)
		!cmp_power_on[2] |-> comparator_two_out == ena_r[`CCD_B_C2INV])
		else $error("comparator 2 invert not applied");
	c3_inv_a: assert property (@(posedge clk) disable iff (!nrst)
		!cmp_power_on[3] |-> comparator_three_out == ena_r[`CCD_B_C3INV])
		else $error("comparator 3 invert not applied");
	req_pulse_a: assert property (@(posedge clk) disable iff (!nrst)
		external_irq_request |=> !external_irq_request)
		else $error("request longer than one cycle");
	src_pin_a: assert property (@(posedge clk) disable iff (!nrst)
		src_r == CCD_SRC_PIN && dbc_r == 6'h00 && !wr_dbc |=> lk.filt == $past(irq_input_pin))
		else $error("pin source not routed to the filter");
	req_after_a: assert property (@(posedge clk) disable iff (!nrst)
		irq_rise |=> external_irq_request)
		else $error("debounced rise gave no request");

	req_c: cover property (@(posedge clk) disable iff (!nrst) external_irq_request);
	reload_hi_c: cover property (@(posedge clk) disable iff (!nrst) wr_dbc && lk.src);
	slverr_c: cover property (@(posedge clk) disable iff (!nrst) pslverr);
	irq_c: cover property (@(posedge clk) disable iff (!nrst) irq);
endmodule

//--- verification/ccd_analog_model.sv
module ccd_analog_model (
	// Controls
	input wire logic [3:0] power,
	input wire logic [3:0] level,
	input wire logic pin_level,
	// Toward design
	output logic [3:0] cmp_raw,
	output logic irq_input_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// Unpowered parts give a meaningless high decision; the design must mask it
	assign cmp_raw = level | ~power;
	// The bench holds the pin low around debounce writes unless testing the fault
	assign irq_input_pin = pin_level;
endmodule

//--- verification/comparator_control_debounce_test.sv
`include "ccd_cfg.svh"
module comparator_control_debounce_test;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int DIV = 2;
	logic clk, nrst, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] cmp_raw, cmp_power_on, lvl;
	logic [1:0] c3sel;
	logic c1sel, c3o, c2o, c2hi, c2lo, pin, pin_lvl, ereq, irq;
	int mismatches, comparisons, req_cnt, n, snap;

	ccd_top #(.DBC_DIV(DIV)) ccd_top_inst (.clk(clk), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_raw(cmp_raw),
		.cmp_power_on(cmp_power_on), .comparator_three_neg_input_sel(c3sel),
		.comparator_one_neg_input_sel(c1sel), .comparator_two_input_sel_hi(c2hi), .comparator_two_input_sel_lo(c2lo),
		.comparator_three_out(c3o), .comparator_two_out(c2o), .irq_input_pin(pin),
		.external_irq_request(ereq), .irq(irq));
	ccd_analog_model ccd_analog_model_inst (.power(cmp_power_on), .level(lvl),
		.pin_level(pin_lvl), .cmp_raw(cmp_raw), .irq_input_pin(pin));

	// ********************************
	// Helpers
	// ********************************
	initial begin
		clk = 0;
		forever #4 clk = ~clk;
	end
	always @(posedge clk) begin
		if (ereq === 1'b1) req_cnt <= req_cnt + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		// A write lands in the update phase of this edge; callers look one edge on
		@(posedge clk);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		apb(0, a, 0);
		check(rd, exp);
	endtask

	// Raises the source, counts cycles to the request, then lets it settle
	task automatic lat(input logic cmp, input int lo, input int hi, input logic ie);
		n = 0;
		if (cmp) lvl[0] <= 1'b1;
		else pin_lvl <= 1'b1;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (ereq !== 1'b1 && n < 200);
		check(n >= lo && n <= hi, 1);
		@(posedge clk);
		check(irq, ie);
		lvl <= 4'h0;
		pin_lvl <= 1'b0;
		repeat (120) @(posedge clk);
		apb(1, `CCD_OFS_STS, 32'h3);
	endtask

	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	initial begin
		#200000;
		mismatches++;
		end_sim();
	end

	// ********************************
	// Sequence
	// ********************************
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, lvl, pin_lvl} = '0;
		mismatches = 0;
		comparisons = 0;
		req_cnt = 0;
		repeat (10) @(posedge clk);
		nrst <= 1;
		rdchk(`CCD_OFS_ENA, 0);
		rdchk(`CCD_OFS_SEL, 0);
		rdchk(`CCD_OFS_DBC, 0);
		check(cmp_power_on, 0);
		apb(1, `CCD_OFS_ENA, 32'hff);
		rdchk(`CCD_OFS_ENA, 32'hdf);
		check(cmp_power_on, 4'hf);
		lvl <= 4'h1;
		rdchk(`CCD_OFS_SEL, 32'h80);
		lvl <= 4'hc;
		rdchk(`CCD_OFS_SEL, 0);
		check({c3o, c2o}, 2'b00);
		lvl <= 4'h0;
		@(posedge clk);
		check({c3o, c2o}, 2'b11);
		lvl <= 4'h1;
		apb(1, `CCD_OFS_ENA, 0);
		rdchk(`CCD_OFS_SEL, 0);
		check(c3o, 0);
		lvl <= 4'h0;
		apb(1, `CCD_OFS_SEL, 32'h40);
		check(c3sel, 2'b01);
		apb(1, `CCD_OFS_SEL, 32'h01);
		check(c3sel, 2'b01);
		apb(1, `CCD_OFS_SEL, 32'h3c);
		check(c3sel, 2'b00);
		check(c1sel, 0);
		check({c2hi, c2lo}, 2'b11);
		rdchk(`CCD_OFS_SEL, 32'h30);
		apb(1, `CCD_OFS_DBC, 32'hff);
		rdchk(`CCD_OFS_DBC, 32'h3f);
		apb(0, 12'h020, 0);
		check(err, 1);
		check(rd, 0);
		apb(1, `CCD_OFS_DBC, 0);
		apb(1, `CCD_OFS_STS, 32'h3);
		apb(1, `CCD_OFS_MSK, 1);
		lat(0, 2, 2, 1);
		check(irq, 0);
		apb(1, `CCD_OFS_MSK, 0);
		apb(1, `CCD_OFS_DBC, 4);
		lat(0, 3 * DIV, 4 * DIV + 4, 0);
		snap = req_cnt;
		pin_lvl <= 1'b1;
		repeat (2) @(posedge clk);
		pin_lvl <= 1'b0;
		repeat (30) @(posedge clk);
		check(req_cnt, snap);
		apb(1, `CCD_OFS_DBC, 63);
		lat(0, 47 * DIV, 48 * DIV + 4, 0);
		pin_lvl <= 1'b1;
		repeat (120) @(posedge clk);
		apb(1, `CCD_OFS_STS, 32'h3);
		snap = req_cnt;
		apb(1, `CCD_OFS_DBC, 0);
		repeat (6) @(posedge clk);
		check(req_cnt, snap + 1);
		pin_lvl <= 1'b0;
		apb(1, `CCD_OFS_SRC, 1);
		apb(1, `CCD_OFS_ENA, 1);
		lat(1, 2, 3, 0);
		apb(1, `CCD_OFS_SRC, 0);
		repeat (5) @(posedge clk);
		snap = req_cnt;
		apb(1, `CCD_OFS_ENA, 32'h10);
		repeat (6) @(posedge clk);
		check(req_cnt, snap + 1);
		end_sim();
	end
endmodule
